// ==== hw/psrm_regs.vh ====
`ifndef PSRM_REGS_VH
`define PSRM_REGS_VH
// Register offsets as seen on the I2C port.
`define PSRM_IIR_COEFF_SELECT       8'hf1
`define PSRM_HS_ENTRY_CODE          8'hf2
`define PSRM_DEVICE_STATUS          8'hf3
`define PSRM_MEASUREMENT_CONTROL    8'hf4
`define PSRM_SERIAL_SETUP           8'hf5
`define PSRM_SOFT_RESET             8'he0
`define PSRM_PRESS_RESULT_HIGH      8'hf7
`define PSRM_PRESS_RESULT_MID       8'hf8
`define PSRM_PRESS_RESULT_LOW       8'hf9
`define PSRM_TEMP_RESULT_HIGH       8'hfa
`define PSRM_TEMP_RESULT_MID        8'hfb
`define PSRM_TEMP_RESULT_LOW        8'hfc
// SPI offsets are the I2C offsets with bit 7 cleared.
`define PSRM_SPI_ADDR_MASK          8'h7f
// Reset values.
`define PSRM_RST_ZERO               8'h00
`define PSRM_RST_HS_ENTRY_CODE      3'h1
`define PSRM_RST_FIELD3             3'h0
`define PSRM_RST_FIELD2             2'h0
`define PSRM_RST_FLAG               1'h0
`define PSRM_SOFT_RESET_KEY         8'he6
// Field positions.
`define PSRM_STANDBY_MSB            7
`define PSRM_STANDBY_LSB            5
`define PSRM_SDI_DRIVER_BIT         2
`define PSRM_THREE_WIRE_BIT         0
`define PSRM_TEMP_AVG_MSB           7
`define PSRM_TEMP_AVG_LSB           5
`define PSRM_PRESS_AVG_MSB          4
`define PSRM_PRESS_AVG_LSB          2
`define PSRM_POWER_MODE_MSB         1
`define PSRM_POWER_MODE_LSB         0
`define PSRM_MEASURE_BIT            3
`define PSRM_OTP_UPDATE_BIT         0
`endif

// ==== hw/psrm_reg_bank.v ====
// Summary of operation
// - Temperature result bits 23..0 split into high, mid, low bytes by rising address.
// - Pressure result bytes use the same layout: bits 23..16 at the lowest address.
// - Result bytes read zero after reset until a conversion loads them; writes ignored.
// - Serial setup holds a three-bit standby interval field, read-write, reset zero.
// - One serial setup bit selects four-wire or three-wire SPI.
// - Another serial setup bit selects the driver type of the data-in pin.
// - Measurement control holds three-bit temperature and pressure averaging fields.
// - Measurement control holds a two-bit operating state; register read-write, reset zero.
// - Status register flags a measurement in progress.
// - Status register flags calibration memory access in progress; resets to zero.
// - A read-write register holds the three-bit high-speed master code, reset one.
// - A read-write register holds the three-bit filter coefficient, reset zero.
// - Writing the key pattern to the reset register resets the device; reads zero.
`timescale 1ns/1ps
`include "psrm_regs.vh"
module psrm_reg_bank (
   // Clock and reset.
   input  wire        clk_sys_i,
   input  wire        rst_i,
   // Register access from the serial front end.
   input  wire        spi_sel_i,
   input  wire [7:0]  reg_addr_i,
   input  wire        reg_wr_i,
   input  wire [7:0]  reg_wdata_i,
   output reg  [7:0]  reg_rdata_o,
   // Conversion results and status from the core.
   input  wire        temp_load_i,
   input  wire [23:0] temp_result_i,
   input  wire        press_load_i,
   input  wire [23:0] press_result_i,
   input  wire        measuring_i,
   input  wire        otp_busy_i,
   // Configuration to the core.
   output wire [2:0]  standby_sel_o,
   output wire        three_wire_select_o,
   output wire        sdi_driver_type_o,
   output wire [2:0]  temp_avg_o,
   output wire [2:0]  press_avg_o,
   output wire [1:0]  power_mode_o,
   output wire [2:0]  hs_master_code_o,
   output wire [2:0]  iir_coeff_o,
   output reg         soft_reset_o
);

   // Decoded address in the I2C form used by the whole map.
   wire [7:0]  addr;
   wire        any_rst;
   // Write strobes, one per writable register.
   wire        wr_iir;
   wire        wr_hs;
   wire        wr_meas;
   wire        wr_setup;
   wire        wr_key;
   wire        key_write;
   // Result bytes gathered from the per-byte stores.
   wire [23:0] temp_bytes;
   wire [23:0] press_bytes;
   wire [7:0]  temp_byte_low;
   wire [7:0]  temp_byte_mid;
   wire [7:0]  temp_byte_high;
   wire [7:0]  press_byte_low;
   wire [7:0]  press_byte_mid;
   wire [7:0]  press_byte_high;
   // Register images as the host reads them.
   wire [7:0]  setup_image;
   wire [7:0]  meas_image;
   wire [7:0]  hs_image;
   wire [7:0]  iir_image;
   // Configuration fields.
   reg  [2:0]  standby_ff;
   reg         three_wire_select_ff;
   reg         sdi_driver_type_ff;
   reg  [2:0]  temp_avg_ff;
   reg  [2:0]  press_avg_ff;
   reg  [1:0]  power_mode_ff;
   reg  [2:0]  hs_code_ff;
   reg  [2:0]  iir_ff;
   // Status, soft reset and read path.
   reg  [7:0]  status_ff;
   reg  [7:0]  nxt_status;
   reg  [7:0]  nxt_rdata;
   reg         soft_rst_ff;
   genvar      k;

   // SPI addresses omit bit 7, so forcing it high folds both ports onto one map.
   assign addr    = spi_sel_i ? (reg_addr_i | ~`PSRM_SPI_ADDR_MASK) : reg_addr_i;
   // A key write clears the bank one cycle later, as a pin reset would, except reg_rdata_o, which only rst_i clears.
   assign any_rst = rst_i | soft_rst_ff;

   // Only listed writable offsets get a strobe, so any other write changes nothing.
   assign wr_iir    = reg_wr_i && (addr == `PSRM_IIR_COEFF_SELECT);
   assign wr_hs     = reg_wr_i && (addr == `PSRM_HS_ENTRY_CODE);
   assign wr_meas   = reg_wr_i && (addr == `PSRM_MEASUREMENT_CONTROL);
   assign wr_setup  = reg_wr_i && (addr == `PSRM_SERIAL_SETUP);
   assign wr_key    = reg_wr_i && (addr == `PSRM_SOFT_RESET);
   assign key_write = wr_key && (reg_wdata_i == `PSRM_SOFT_RESET_KEY);

   // Byte k holds result bits [8k+7:8k]; a load replaces all three bytes at once.
   generate
      for (k = 0; k < 3; k = k + 1) begin : g_result
         reg [7:0] temp_part_ff;
         reg [7:0] press_part_ff;

         always @(posedge clk_sys_i) begin
            if (any_rst) begin
               temp_part_ff <= `PSRM_RST_ZERO;
            end else if (temp_load_i) begin
               temp_part_ff <= temp_result_i[8*k+7:8*k];
            end
         end

         always @(posedge clk_sys_i) begin
            if (any_rst) begin
               press_part_ff <= `PSRM_RST_ZERO;
            end else if (press_load_i) begin
               press_part_ff <= press_result_i[8*k+7:8*k];
            end
         end

         assign temp_bytes[8*k+7:8*k]  = temp_part_ff;
         assign press_bytes[8*k+7:8*k] = press_part_ff;
      end
   endgenerate

   assign temp_byte_low   = temp_bytes[7:0];
   assign temp_byte_mid   = temp_bytes[15:8];
   assign temp_byte_high  = temp_bytes[23:16];
   assign press_byte_low  = press_bytes[7:0];
   assign press_byte_mid  = press_bytes[15:8];
   assign press_byte_high = press_bytes[23:16];

   always @(posedge clk_sys_i) begin
      if (any_rst) begin
         standby_ff <= `PSRM_RST_FIELD3;
      end else if (wr_setup) begin
         standby_ff <= reg_wdata_i[`PSRM_STANDBY_MSB:`PSRM_STANDBY_LSB];
      end
   end

   always @(posedge clk_sys_i) begin
      if (any_rst) begin
         three_wire_select_ff <= `PSRM_RST_FLAG;
      end else if (wr_setup) begin
         three_wire_select_ff <= reg_wdata_i[`PSRM_THREE_WIRE_BIT];
      end
   end

   always @(posedge clk_sys_i) begin
      if (any_rst) begin
         sdi_driver_type_ff <= `PSRM_RST_FLAG;
      end else if (wr_setup) begin
         sdi_driver_type_ff <= reg_wdata_i[`PSRM_SDI_DRIVER_BIT];
      end
   end

   always @(posedge clk_sys_i) begin
      if (any_rst) begin
         temp_avg_ff <= `PSRM_RST_FIELD3;
      end else if (wr_meas) begin
         temp_avg_ff <= reg_wdata_i[`PSRM_TEMP_AVG_MSB:`PSRM_TEMP_AVG_LSB];
      end
   end

   always @(posedge clk_sys_i) begin
      if (any_rst) begin
         press_avg_ff <= `PSRM_RST_FIELD3;
      end else if (wr_meas) begin
         press_avg_ff <= reg_wdata_i[`PSRM_PRESS_AVG_MSB:`PSRM_PRESS_AVG_LSB];
      end
   end

   always @(posedge clk_sys_i) begin
      if (any_rst) begin
         power_mode_ff <= `PSRM_RST_FIELD2;
      end else if (wr_meas) begin
         power_mode_ff <= reg_wdata_i[`PSRM_POWER_MODE_MSB:`PSRM_POWER_MODE_LSB];
      end
   end

   // The master code comes out of reset at one, unlike every other field.
   always @(posedge clk_sys_i) begin
      if (any_rst) begin
         hs_code_ff <= `PSRM_RST_HS_ENTRY_CODE;
      end else if (wr_hs) begin
         hs_code_ff <= reg_wdata_i[2:0];
      end
   end

   always @(posedge clk_sys_i) begin
      if (any_rst) begin
         iir_ff <= `PSRM_RST_FIELD3;
      end else if (wr_iir) begin
         iir_ff <= reg_wdata_i[2:0];
      end
   end

   // Unused bits of each register read as zero.
   assign setup_image = {standby_ff, 2'h0, sdi_driver_type_ff, 1'h0, three_wire_select_ff};
   assign meas_image  = {temp_avg_ff, press_avg_ff, power_mode_ff};
   assign hs_image    = {5'h00, hs_code_ff};
   assign iir_image   = {5'h00, iir_ff};

   // The key write raises a one-cycle reset that also clears this bank.
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         soft_rst_ff  <= 1'h0;
         soft_reset_o <= 1'h0;
      end else begin
         soft_rst_ff  <= key_write;
         soft_reset_o <= key_write;
      end
   end

   always @* begin
      nxt_status = `PSRM_RST_ZERO;
      nxt_status[`PSRM_MEASURE_BIT]    = measuring_i;
      nxt_status[`PSRM_OTP_UPDATE_BIT] = otp_busy_i;
   end

   always @(posedge clk_sys_i) begin
      if (any_rst) begin
         status_ff <= `PSRM_RST_ZERO;
      end else begin
         status_ff <= nxt_status;
      end
   end

   always @* begin
      case (addr)
         `PSRM_TEMP_RESULT_LOW: begin
            nxt_rdata = temp_byte_low;
         end
         `PSRM_TEMP_RESULT_MID: begin
            nxt_rdata = temp_byte_mid;
         end
         `PSRM_TEMP_RESULT_HIGH: begin
            nxt_rdata = temp_byte_high;
         end
         `PSRM_PRESS_RESULT_LOW: begin
            nxt_rdata = press_byte_low;
         end
         `PSRM_PRESS_RESULT_MID: begin
            nxt_rdata = press_byte_mid;
         end
         `PSRM_PRESS_RESULT_HIGH: begin
            nxt_rdata = press_byte_high;
         end
         `PSRM_SERIAL_SETUP: begin
            nxt_rdata = setup_image;
         end
         `PSRM_MEASUREMENT_CONTROL: begin
            nxt_rdata = meas_image;
         end
         `PSRM_DEVICE_STATUS: begin
            nxt_rdata = status_ff;
         end
         `PSRM_HS_ENTRY_CODE: begin
            nxt_rdata = hs_image;
         end
         `PSRM_IIR_COEFF_SELECT: begin
            nxt_rdata = iir_image;
         end
         `PSRM_SOFT_RESET: begin
            nxt_rdata = `PSRM_RST_ZERO;
         end
         default: begin
            nxt_rdata = `PSRM_RST_ZERO;
         end
      endcase
   end

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         reg_rdata_o <= `PSRM_RST_ZERO;
      end else begin
         reg_rdata_o <= nxt_rdata;
      end
   end

   assign standby_sel_o       = standby_ff;
   assign three_wire_select_o = three_wire_select_ff;
   assign sdi_driver_type_o   = sdi_driver_type_ff;
   assign temp_avg_o          = temp_avg_ff;
   assign press_avg_o         = press_avg_ff;
   assign power_mode_o        = power_mode_ff;
   assign hs_master_code_o    = hs_code_ff;
   assign iir_coeff_o         = iir_ff;

endmodule

// ==== bench/psrm_reg_bank_sva.sv ====
`timescale 1ns/1ps
module psrm_reg_bank_sva (
   input wire       clk_sys_i, rst_i, spi_sel_i, reg_wr_i, measuring_i, otp_busy_i,
   input wire       three_wire_select_o, sdi_driver_type_o, soft_reset_o,
   input wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
   input wire [2:0] standby_sel_o, temp_avg_o, press_avg_o, hs_master_code_o, iir_coeff_o,
   input wire [1:0] power_mode_o
);
   wire [7:0] a = spi_sel_i ? {1'b1, reg_addr_i[6:0]} : reg_addr_i;
   wire [7:0] d = reg_wdata_i;
   wire w = reg_wr_i && !soft_reset_o;
   wire [18:0] cfg = {standby_sel_o, three_wire_select_o, sdi_driver_type_o, temp_avg_o,
                      press_avg_o, power_mode_o, hs_master_code_o, iir_coeff_o};
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   AST_MEAS: assert property (w && a == 8'hf4 |=>
      {temp_avg_o, press_avg_o, power_mode_o} == $past(d)) else $error("meas ctrl");
   AST_SETUP: assert property (w && a == 8'hf5 |=>
      {standby_sel_o, sdi_driver_type_o, three_wire_select_o} == $past({d[7:5], d[2], d[0]}))
      else $error("setup");
   AST_HS: assert property (w && a == 8'hf2 |=>
      hs_master_code_o == $past(d[2:0])) else $error("hs code");
   AST_IIR: assert property (w && a == 8'hf1 |=>
      iir_coeff_o == $past(d[2:0])) else $error("iir");
   AST_STAT: assert property (a == 8'hf3 |=>
      reg_rdata_o == {4'h0, $past(measuring_i, 2), 2'h0, $past(otp_busy_i, 2)}) else $error("stat");
   AST_HOLD: assert property (!(reg_wr_i && a inside {8'hf1, 8'hf2, 8'hf4, 8'hf5})
      && !soft_reset_o |=> $stable(cfg)) else $error("cfg moved");
   AST_SRST: assert property (w && a == 8'he0 && d == 8'he6 |=>
      soft_reset_o ##1 !soft_reset_o) else $error("no pulse");
   AST_SRC: assert property (soft_reset_o |->
      $past(reg_wr_i && a == 8'he0 && d == 8'he6)) else $error("stray pulse");
endmodule
bind psrm_reg_bank psrm_reg_bank_sva chk (.*);

// ==== bench/psrm_host.sv ====
`timescale 1ns/1ps
module psrm_host (
   input  wire       clk_sys_i,
   input  wire [7:0] reg_rdata_i,
   output reg        spi_sel_o = 1'b0,
   output reg  [7:0] reg_addr_o = 8'h00,
   output reg        reg_wr_o = 1'b0,
   output reg  [7:0] reg_wdata_o = 8'h00
);
   // Bit 8 of the address argument selects the SPI address form.
   task wr(input [8:0] a, input [7:0] v);
      @(posedge clk_sys_i);
      {spi_sel_o, reg_addr_o} <= a;
      reg_wr_o <= 1'b1;
      reg_wdata_o <= v;
      @(posedge clk_sys_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~v;
   endtask
   task rd(input [8:0] a, output [7:0] v);
      @(posedge clk_sys_i);
      {spi_sel_o, reg_addr_o} <= a;
      @(posedge clk_sys_i);
      #1 v = reg_rdata_i;
   endtask
endmodule

// ==== bench/tb_psrm_reg_bank.sv ====
`timescale 1ns/1ps
module tb_psrm_reg_bank;
   reg         clk_sys_i = 1'b0, rst_i = 1'b1, measuring_i = 1'b0, otp_busy_i = 1'b0;
   reg         temp_load_i = 1'b0, press_load_i = 1'b0;
   reg  [23:0] temp_result_i = 24'h123456, press_result_i = 24'habcdef;
   wire        spi_sel_i, reg_wr_i, three_wire_select_o, sdi_driver_type_o, soft_reset_o;
   wire [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
   wire [2:0]  standby_sel_o, temp_avg_o, press_avg_o, hs_master_code_o, iir_coeff_o;
   wire [1:0]  power_mode_o;
   reg  [7:0]  v;
   reg  [47:0] res;
   integer     err_total = 0, tests_run = 0, cyc = 0, i;
   psrm_host host (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata_o), .spi_sel_o(spi_sel_i),
      .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i));
   psrm_reg_bank dut (.*);
   initial begin
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   task close_out;
      if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task rchk(input [8:0] a, input [7:0] exp);
      host.rd(a, v);
      chk(v, exp);
   endtask
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total = err_total + 1;
         close_out;
      end
   end
   initial begin
      repeat (10) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      for (i = 8'hf1; i <= 8'hfc; i = i + 1)
         if (i != 8'hf6) rchk(i[8:0], i == 8'hf2 ? 8'h01 : 8'h00);
      rchk(9'h0e0, 8'h00);
      host.wr(9'h174, 8'ha5);
      rchk(9'h0f4, 8'ha5);
      chk({temp_avg_o, press_avg_o, power_mode_o}, 8'ha5);
      host.wr(9'h0f5, 8'hff);
      rchk(9'h175, 8'he5);
      chk({standby_sel_o, 2'h0, sdi_driver_type_o, 1'h0, three_wire_select_o}, 8'he5);
      host.wr(9'h0f2, 8'hfa);
      host.wr(9'h0f1, 8'hfd);
      @(negedge clk_sys_i);
      chk({2'h0, hs_master_code_o, iir_coeff_o}, 8'h15);
      for (i = 8'hf3; i <= 8'hfc; i = i + 1)
         if (i != 8'hf4 && i != 8'hf5) host.wr(i[8:0], 8'hff);
      rchk(9'h0f4, 8'ha5);
      rchk(9'h0fc, 8'h00);
      @(posedge clk_sys_i);
      {temp_load_i, press_load_i, measuring_i, otp_busy_i} <= 4'hf;
      @(posedge clk_sys_i);
      {temp_load_i, press_load_i} <= 2'h0;
      res = {press_result_i, temp_result_i};
      for (i = 0; i < 6; i = i + 1)
         rchk(9'h0f7 + i[8:0], res[47 - 8 * i -: 8]);
      rchk(9'h0f3, 8'h09);
      @(posedge clk_sys_i);
      {measuring_i, otp_busy_i} <= 2'h0;
      host.wr(9'h0e0, 8'he6);
      repeat (2) @(posedge clk_sys_i);
      rchk(9'h0f2, 8'h01);
      rchk(9'h0fa, 8'h00);
      close_out;
   end
endmodule
